// [core/prs_link_core.sv]
`timescale 1ns/1ns

// Function
// - one-clock sync pulse aligns word boundaries
// - line held beyond one clock resets device
// - pulses under 200 ns never reset the device
// - management reset bit resets like hardware
// - 100 Mb/s mode drives 50 MHz clock
// - 10 Mb/s mode drives 5 MHz clock
// - link clock stops only while CE is low or the internal reset holds (RST_N low, then two clocks more)
// - reduced power keeps 5 MHz clock
module prs_link_core (
  // clock, enable and reset
  input  wire logic                     MCLK,
  input  wire logic                     CE,
  input  wire logic                     RST_N,
  // host reset/sync pin
  input  wire logic                     HOST_RESET_SYNC_LINE,
  // operating mode from the device's own logic
  input  wire logic                     SPEED_100,
  input  wire logic                     LOW_POWER,
  // management control register zero, reset bit written as one
  input  wire logic                     MGMT_RESET_WR,
  // link clock toward the host
  output logic                          PHY_LINK_CLOCK_OUT,
  // device-wide reset and word alignment
  output logic                          DEVICE_RESET,
  output logic                          WORD_SYNC,
  output logic [prs_pkg::BIT_W-1:0]     WORD_BIT
);

  logic                         rst_meta_reg;
  logic                         rst_n_i;
  logic                         line_meta_reg;
  logic                         line_reg;
  logic                         line_d_reg;
  logic [prs_pkg::DIV_W-1:0]    div_reg;
  logic [prs_pkg::DIV_W-1:0]    half_reg;
  logic                         lclk_reg;
  logic [prs_pkg::WID_W-1:0]    wid_reg;
  logic [1:0]                   hi_reg;
  logic                         hw_rst_reg;
  logic [4:0]                   soft_reg;
  logic                         dev_rst_reg;
  logic                         sync_reg;
  logic [prs_pkg::BIT_W-1:0]    bit_reg;
  prs_pkg::prs_mode_s           mode;

  // reset release through two flops
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_i      <= 1'b0;
    end
    else if (CE)
    begin
      rst_meta_reg <= 1'b1;
      rst_n_i      <= rst_meta_reg;
    end
  end

  // pin synchroniser; only line_reg and line_d_reg are read by logic
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_meta_reg <= 1'b0;
      line_reg      <= 1'b0;
      line_d_reg    <= 1'b0;
    end
    else if (CE)
    begin
      line_meta_reg <= HOST_RESET_SYNC_LINE;
      line_reg      <= line_meta_reg;
      line_d_reg    <= line_reg;
    end
  end

  // mode decode and link clock divider terms
  wire                       tick      = (div_reg == half_reg - 4'h1);
  wire                       rise      = tick & ~lclk_reg;
  wire                       fast_sel  = mode.speed_100 & ~mode.low_power;
  wire [prs_pkg::DIV_W-1:0]  half_sel  = fast_sel ? prs_pkg::HALF_FAST
                                                  : prs_pkg::HALF_SLOW;
  wire [prs_pkg::DIV_W-1:0]  div_next  = tick ? prs_pkg::DIV_RST
                                              : div_reg + 4'h1;
  assign mode.speed_100 = SPEED_100;
  assign mode.low_power = LOW_POWER;

  // free-running link clock; rate changes only at a falling edge so no
  // short phase ever leaves the pin, and device reset does not stop it
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_reg  <= prs_pkg::DIV_RST;
      half_reg <= prs_pkg::HALF_SLOW;
      lclk_reg <= 1'b0;
    end
    else if (CE)
    begin
      div_reg <= div_next;
      if (tick)
        lclk_reg <= ~lclk_reg;
      if (tick && lclk_reg)
        half_reg <= half_sel;
    end
  end

  // pulse measurement on the synchronised line
  wire       fall_w    = line_d_reg & ~line_reg;
  wire [prs_pkg::WID_W-1:0] sync_min =
    prs_pkg::WID_W'({half_reg, 1'b0} - 5'h01);
  wire       sync_det  = fall_w && (hi_reg == prs_pkg::HI_ONE)
                         && (wid_reg >= sync_min);
  wire       hw_rst_set = line_reg && (hi_reg == prs_pkg::HI_MAX)
                          && (wid_reg >= prs_pkg::NOISE_MIN);
  wire       hw_rst_next = line_reg & (hw_rst_reg | hw_rst_set);
  wire [4:0] soft_next = MGMT_RESET_WR ? prs_pkg::SOFT_RST_CYC
                         : (soft_reg != 5'h00) ? soft_reg - 5'h01
                                               : 5'h00;
  wire       dev_rst_next = hw_rst_next | MGMT_RESET_WR
                            | (soft_next != 5'h00);

  // width and rise counters, cleared whenever the line is low
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wid_reg <= prs_pkg::WID_RST;
      hi_reg  <= 2'h0;
    end
    else if (CE)
    begin
      if (!line_reg)
      begin
        wid_reg <= prs_pkg::WID_RST;
        hi_reg  <= 2'h0;
      end
      else
      begin
        if (wid_reg != prs_pkg::WID_MAX)
          wid_reg <= wid_reg + 5'h01;
        if (rise && hi_reg != prs_pkg::HI_MAX)
          hi_reg <= hi_reg + 2'h1;
      end
    end
  end

  // device reset: held while a long pulse lasts, or a fixed stretch
  // after the management reset bit is written
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hw_rst_reg  <= 1'b0;
      soft_reg    <= 5'h00;
      dev_rst_reg <= 1'b1;
    end
    else if (CE)
    begin
      hw_rst_reg  <= hw_rst_next;
      soft_reg    <= soft_next;
      dev_rst_reg <= dev_rst_next;
    end
  end

  // word alignment; the bit counter parks on the last bit so the first
  // link rise after a sync carries bit zero of the next word
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_reg <= 1'b0;
      bit_reg  <= prs_pkg::BIT_RST;
    end
    else if (CE)
    begin
      sync_reg <= sync_det & ~dev_rst_next;
      if (dev_rst_next || sync_det)
        bit_reg <= prs_pkg::BIT_LAST;
      else if (rise)
        bit_reg <= bit_reg + 3'h1;
    end
  end

  assign PHY_LINK_CLOCK_OUT = lclk_reg;
  assign DEVICE_RESET       = dev_rst_reg;
  assign WORD_SYNC          = sync_reg;
  assign WORD_BIT           = bit_reg;

  // cycles since the link clock last changed, for the liveness check
  logic [4:0] stall_reg;
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stall_reg <= 5'h00;
    else if (CE)
      stall_reg <= tick ? 5'h00 : stall_reg + 5'h01;
  end

  // a sync was reported and no link rise has come since; the restart
  // check must span the gap, since in slow mode the rise comes late
  logic       sync_wait_reg;
  always_ff @(posedge MCLK or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_wait_reg <= 1'b0;
    else if (CE)
      sync_wait_reg <= (sync_wait_reg | sync_reg) & ~rise;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n_i);

  a_half_legal: assert property (
    half_reg == prs_pkg::HALF_FAST || half_reg == prs_pkg::HALF_SLOW)
    else $error("link clock half period illegal");
  a_clock_alive: assert property (
    stall_reg < 5'(prs_pkg::HALF_SLOW))
    else $error("link clock stalled");
  a_fast_toggle: assert property (
    (CE && half_reg == prs_pkg::HALF_FAST)
    |=> (lclk_reg != $past(lclk_reg)))
    else $error("fast link clock did not toggle");
  a_slow_hold: assert property (
    (CE && tick && half_reg == prs_pkg::HALF_SLOW)
    |-> stall_reg == 5'(prs_pkg::HALF_SLOW) - 5'h01)
    else $error("slow link clock phase not ten cycles");
  a_low_power_slow: assert property (
    (CE && tick && lclk_reg && (mode.low_power || !mode.speed_100))
    |=> half_reg == prs_pkg::HALF_SLOW)
    else $error("low rate not chosen");
  a_sync_word: assert property (
    (CE && sync_det && !dev_rst_next)
    |=> WORD_SYNC && WORD_BIT == prs_pkg::BIT_LAST)
    else $error("sync pulse not reported");
  a_word_restart: assert property (
    (CE && (sync_reg || sync_wait_reg) && rise
     && !sync_det && !dev_rst_next)
    |=> WORD_BIT == 3'h0)
    else $error("word did not restart after sync");
  a_hw_reset: assert property (
    (CE && hw_rst_set) |=> DEVICE_RESET && !WORD_SYNC)
    else $error("long pulse did not reset");
  a_noise_drop: assert property (
    (CE && fall_w && wid_reg < sync_min) |=> !WORD_SYNC)
    else $error("narrow pulse taken as sync");
  a_noise_norst: assert property (
    (CE && wid_reg < prs_pkg::NOISE_MIN && !hw_rst_reg) |-> !hw_rst_next)
    else $error("narrow pulse taken as reset");
  a_soft_reset: assert property (
    (CE && MGMT_RESET_WR) ##1 CE[*8] |-> DEVICE_RESET[*8])
    else $error("management reset too short");

  c_sync: cover property (WORD_SYNC);
  c_hw_reset: cover property ($rose(hw_rst_reg));
  c_soft_reset: cover property (CE && MGMT_RESET_WR);
  c_rate_up: cover property (half_reg == prs_pkg::HALF_SLOW
                             ##1 half_reg == prs_pkg::HALF_FAST);

endmodule

// [core/prs_pkg.sv]
package prs_pkg;

  // clock rates
  localparam int unsigned MCLK_HZ      = 100_000_000;
  localparam int unsigned LINK_HZ_FAST = 50_000_000;
  localparam int unsigned LINK_HZ_SLOW = 5_000_000;

  // divider width and half-period counts of the link clock
  localparam int unsigned DIV_W = 4;
  localparam logic [DIV_W-1:0] HALF_FAST =
    DIV_W'(MCLK_HZ / (2 * LINK_HZ_FAST));
  localparam logic [DIV_W-1:0] HALF_SLOW =
    DIV_W'(MCLK_HZ / (2 * LINK_HZ_SLOW));

  // noise filter on the reset/sync line, least width rounds up
  localparam int unsigned NOISE_NS  = 200;
  localparam int unsigned NOISE_CYC =
    (NOISE_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

  // pulse width counter, saturating
  localparam int unsigned WID_W = 5;
  localparam logic [WID_W-1:0] WID_MAX   = 5'h1F;
  localparam logic [WID_W-1:0] NOISE_MIN = WID_W'(NOISE_CYC);

  // link-clock rises seen while the line is high, saturating at two
  localparam logic [1:0] HI_ONE = 2'h1;
  localparam logic [1:0] HI_MAX = 2'h2;

  // length of the reset issued by the management reset bit
  localparam logic [4:0] SOFT_RST_CYC = 5'h10;

  // link word bit counter
  localparam int unsigned      BIT_W    = 3;
  localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;

  // values after reset
  localparam logic [DIV_W-1:0] DIV_RST  = 4'h0;
  localparam logic [BIT_W-1:0] BIT_RST  = 3'h7;
  localparam logic [WID_W-1:0] WID_RST  = 5'h00;

  // operating mode as seen by the link clock generator
  typedef struct packed {
    logic speed_100;
    logic low_power;
  } prs_mode_s;

endpackage

// [tb/prs_host_model.sv]
`timescale 1ns/1ns

// host end of the link: raises the reset/sync line just after a link clock
// rise and drops it after the asked number of further rises
module prs_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // link clock from the device
  input  wire logic        link_clk,
  // request and its length in link clock rises
  input  wire logic        go,
  input  wire logic [11:0] rises,
  // forced short pulse, only for noise scenarios
  input  wire logic        glitch,
  // reset/sync line toward the device
  output logic             line
);
  logic        link_q;
  logic        armed;
  logic        hold;
  logic [11:0] left;
  logic        rise;

  // rise found by sampling, so the line moves one cycle after it
  assign rise = link_clk & ~link_q;
  assign line = hold | glitch;

  // one rise held gives a sync, a long hold a reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_q <= 1'b0;
      armed  <= 1'b0;
      hold   <= 1'b0;
      left   <= 12'h000;
    end
    else
    begin
      link_q <= link_clk;
      if (go)
        armed <= 1'b1;
      if (rise && armed)
      begin
        armed <= 1'b0;
        hold  <= 1'b1;
        left  <= rises;
      end
      else if (rise && hold && left == 12'h001)
        hold <= 1'b0;
      else if (rise && hold)
        left <= left - 12'h001;
    end
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ns

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb;
  typedef struct packed {logic spd; logic lp; logic [3:0] half;} prs_row_s;
  logic        mclk;
  logic        ce;
  logic        rst_n;
  logic        spd;
  logic        lp;
  logic        mgmt;
  logic        go;
  logic        glitch;
  logic [11:0] rises;
  logic        line;
  logic        link_clk;
  logic        dev_rst;
  logic        wsync;
  logic [2:0]  wbit;
  logic        lq;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          syncs = 0;
  int          rsts = 0;
  int          cyc = 0;
  int          n;
  int          t;
  int          tog;
  // mode inputs beside the high phase they give, in clock cycles
  prs_row_s    rows [4] = '{'{1'b1, 1'b0, 4'h1}, '{1'b0, 1'b0, 4'hA},
                            '{1'b1, 1'b1, 4'hA}, '{1'b0, 1'b1, 4'hA}};

  prs_link_core prs_link_core_i (.MCLK(mclk), .CE(ce), .RST_N(rst_n),
    .HOST_RESET_SYNC_LINE(line), .SPEED_100(spd), .LOW_POWER(lp),
    .MGMT_RESET_WR(mgmt), .PHY_LINK_CLOCK_OUT(link_clk),
    .DEVICE_RESET(dev_rst), .WORD_SYNC(wsync), .WORD_BIT(wbit));
  prs_host_model prs_host_model_i (.clk(mclk), .rst_n(rst_n),
    .link_clk(link_clk), .go(go), .rises(rises), .glitch(glitch),
    .line(line));

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // tallies of cycles with sync or reset high, so a late stray pulse is still caught
  always @(negedge mclk)
  begin
    if (wsync === 1'b1)
      syncs++;
    if (dev_rst === 1'b1)
      rsts++;
  end

  // hang guard, well above the long reset scenario
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task link_rise();
    for (int j = 0; j < 50 && link_clk !== 1'b0; j++) @(negedge mclk);
    for (int j = 0; j < 50 && link_clk !== 1'b1; j++) @(negedge mclk);
  endtask

  task host_req(input logic [11:0] r);
    @(posedge mclk);
    rises <= r;
    go    <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  // short pulse just after a rise: neither sync nor reset may follow
  task noise(input int w);
    t = syncs;
    n = rsts;
    link_rise();
    @(posedge mclk);
    glitch <= 1'b1;
    repeat (w) @(posedge mclk);
    glitch <= 1'b0;
    repeat (60) @(negedge mclk);
    `CHK(syncs, t)
    `CHK(rsts, n)
    $display("noise width %0d done", w);
  endtask

  initial
  begin
    {rst_n, spd, lp, mgmt, go, glitch, rises} = '0;
    ce = 1'b1;
    repeat (20) @(negedge mclk);
    `CHK(dev_rst, 1'b1)
    `CHK(wbit, 3'h7)
    $display("reset checks done");
    @(posedge mclk);
    rst_n <= 1'b1;
    // internal reset ends two edges later; inputs move from the fourth
    repeat (3) @(posedge mclk);
    foreach (rows[i])
    begin
      @(posedge mclk);
      spd <= rows[i].spd;
      lp  <= rows[i].lp;
      repeat (40) @(negedge mclk);
      link_rise();
      for (n = 0; n < 50 && link_clk === 1'b1; n++) @(negedge mclk);
      `CHK(n, int'(rows[i].half))
      host_req(12'h001);
      for (int j = 0; j < 80 && wsync !== 1'b1; j++) @(negedge mclk);
      `CHK(wsync, 1'b1)
      `CHK(wbit, 3'h7)
      `CHK(dev_rst, 1'b0)
      for (int j = 0; j < 40 && wbit === 3'h7; j++) @(negedge mclk);
      `CHK(wbit, 3'h0)
      $display("mode row %0d done", i);
    end
    noise(3);
    @(posedge mclk);
    spd <= 1'b1;
    lp  <= 1'b0;
    noise(15);
    @(posedge mclk);
    mgmt <= 1'b1;
    @(posedge mclk);
    mgmt <= 1'b0;
    t = rsts;
    repeat (30) @(negedge mclk);
    `CHK(rsts - t, 16)
    $display("management reset done");
    // enable low freezes the fast link clock where it stands
    @(posedge mclk);
    ce <= 1'b0;
    @(negedge mclk);
    lq = link_clk;
    repeat (30) @(negedge mclk);
    `CHK(link_clk, lq)
    @(posedge mclk);
    ce <= 1'b1;
    $display("clock enable hold done");
    @(posedge mclk);
    spd <= 1'b0;
    t = syncs;
    host_req(12'h9C4);
    for (int j = 0; j < 200 && dev_rst !== 1'b1; j++) @(negedge mclk);
    `CHK(dev_rst, 1'b1)
    n = 0;
    tog = 0;
    lq = link_clk;
    while (dev_rst === 1'b1 && n < 60000)
    begin
      n++;
      tog += int'(link_clk !== lq);
      lq = link_clk;
      @(negedge mclk);
    end
    `CHK(n inside {[49900:50010]}, 1'b1)
    `CHK(tog > 4900, 1'b1)
    `CHK(syncs, t)
    $display("long reset done");
    print_verdict();
  end
endmodule
